// [rtl/pudc_defs.vh]
// register map, field layout and reset values of the pulse up/down counter
`ifndef PUDC_DEFS_VH
`define PUDC_DEFS_VH

// register byte offsets on the wishbone slave
`define PUDC_OFF_CTRL 8'h00
`define PUDC_OFF_PRESCALE 8'h04
`define PUDC_OFF_UPPER 8'h08
`define PUDC_OFF_DISP_LIM 8'h0C
`define PUDC_OFF_COUNT 8'h10
`define PUDC_OFF_DISPLAY 8'h14
`define PUDC_OFF_IRQ_STAT 8'h18
`define PUDC_OFF_IRQ_CLR 8'h1C
`define PUDC_OFF_IRQ_EN 8'h20

// control register fields
`define PUDC_CTL_W 9
`define PUDC_CTL_DOWN 0
`define PUDC_CTL_FALL 1
`define PUDC_CTL_SRC 3:2
`define PUDC_CTL_LIM 5:4
`define PUDC_CTL_DP 8:6

// input source encodings
`define PUDC_SRC_LOGIC 2'h0
`define PUDC_SRC_SINK 2'h1
`define PUDC_SRC_SOURCE 2'h2

// range limit encodings
`define PUDC_LIM_OFF 2'h0
`define PUDC_LIM_ERR 2'h1
`define PUDC_LIM_CLAMP 2'h2

// interrupt status bits
`define PUDC_IRQ_W 4
`define PUDC_IRQ_PULSE 0
`define PUDC_IRQ_LIMIT 1
`define PUDC_IRQ_ERROR 2
`define PUDC_IRQ_EXTRST 3

// display register fields
`define PUDC_DSP_ERR 31
`define PUDC_DSP_DP 26:24

// reset values
`define PUDC_RST_CTRL 9'h000
`define PUDC_RST_PRESCALE 16'h0001
`define PUDC_RST_UPPER 24'h00FFFF
`define PUDC_RST_DISP_LIM 16'h270F

`endif

// [rtl/pudc_scaler.v]
// sequential count-to-display scaler: count * scale / limit
`default_nettype none

module pudc_scaler #(
    parameter CW = 24,
    parameter DW = 16
) (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire [CW-1:0] count,
    input wire [DW-1:0] scale,
    input wire [CW-1:0] limit,
    output wire idle,
    output reg done_r,
    output reg [DW-1:0] quot_r
);
    localparam NW = CW + DW;
    localparam IW = $clog2(NW + 1);
    localparam [2:0] SC_IDLE = 3'b001;
    localparam [2:0] SC_RUN = 3'b010;
    localparam [2:0] SC_DONE = 3'b100;
    localparam [IW-1:0] STEPS = NW;
    localparam [IW-1:0] ONE = 1;

    reg [2:0] state_r;
    reg [NW-1:0] num_r;
    reg [CW:0] rem_r;
    reg [CW-1:0] lim_r;
    reg [IW-1:0] step_r;
    wire [CW:0] rem_sh;
    wire fits;
    wire sat;

    // one restoring step: numerator bits shift out the top into the remainder, quotient bits shift in at the bottom
    assign rem_sh = {rem_r[CW-1:0], num_r[NW-1]};
    assign fits = (rem_sh >= {1'b0, lim_r});
    assign idle = state_r[0];
    // result wider than the display saturates rather than wraps
    assign sat = |num_r[NW-1:DW];

    // division state machine, about NW+2 cycles per result
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= SC_IDLE;
            num_r <= {NW{1'b0}};
            rem_r <= {(CW+1){1'b0}};
            lim_r <= {CW{1'b0}};
            step_r <= {IW{1'b0}};
            done_r <= 1'b0;
            quot_r <= {DW{1'b0}};
        end
        else
        begin
            done_r <= 1'b0;
            case (state_r)
                SC_IDLE:
                begin
                    if (start)
                    begin
                        num_r <= count * scale;
                        lim_r <= limit;
                        rem_r <= {(CW+1){1'b0}};
                        step_r <= STEPS;
                        state_r <= SC_RUN;
                    end
                end
                SC_RUN:
                begin
                    rem_r <= fits ? (rem_sh - {1'b0, lim_r}) : rem_sh;
                    num_r <= {num_r[NW-2:0], fits};
                    step_r <= step_r - ONE;
                    if (step_r == ONE)
                        state_r <= SC_DONE;
                end
                SC_DONE:
                begin
                    // zero limit divides by zero: show full scale
                    if (sat || lim_r == {CW{1'b0}})
                        quot_r <= {DW{1'b1}};
                    else
                        quot_r <= num_r[DW-1:0];
                    done_r <= 1'b1;
                    state_r <= SC_IDLE;
                end
                default:
                    state_r <= SC_IDLE;
            endcase
        end
    end
endmodule // pudc_scaler

`default_nettype wire

// [rtl/pudc_top.v]
// pulse up/down counter with prescaler, range limits and wishbone registers
`include "pudc_defs.vh"
`default_nettype none

module pudc_top #(
    parameter CW = 24,
    parameter PW = 16,
    parameter DW = 16
) (
    input wire clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire cnt_pin,
    input wire ext_rst_pin_n,
    output wire pull_up_en,
    output wire pull_down_en,
    input wire nv_load_valid,
    input wire [CW-1:0] nv_load_value,
    output reg nv_save_stb,
    output reg [CW-1:0] nv_save_value,
    output reg [DW-1:0] disp_value,
    output reg [2:0] disp_dp,
    output reg disp_err,
    output wire irq
);
    localparam [1:0] ST_RESTORE = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;
    localparam [CW-1:0] ABS_MAX = {CW{1'b1}};
    localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
    localparam [CW-1:0] CNT_ONE = 1;
    localparam [PW-1:0] PRE_ONE = 1;
    localparam [`PUDC_CTL_W-1:0] RST_CTRL = `PUDC_RST_CTRL;
    localparam [PW-1:0] RST_PRE = `PUDC_RST_PRESCALE;
    localparam [CW-1:0] RST_UPPER = `PUDC_RST_UPPER;
    localparam [DW-1:0] RST_DLIM = `PUDC_RST_DISP_LIM;

    // configuration and status registers
    reg [`PUDC_CTL_W-1:0] ctrl_r;
    reg [PW-1:0] prescale_r;
    reg [CW-1:0] upper_r;
    reg [DW-1:0] disp_lim_r;
    reg [`PUDC_IRQ_W-1:0] irq_stat_r;
    reg [`PUDC_IRQ_W-1:0] irq_en_r;
    // pin synchronisers and edge history
    reg cnt_s1_r;
    reg cnt_s2_r;
    reg cnt_d_r;
    reg ers_s1_r;
    reg ers_s2_r;
    reg ers_d_r;
    // counting core
    reg [1:0] state_r;
    reg [PW-1:0] pre_cnt_r;
    reg [CW-1:0] count_r;
    reg [CW-1:0] count_nxt;
    reg over_r;
    reg over_nxt;
    reg under_r;
    reg under_nxt;
    reg abs_err_r;
    reg abs_err_nxt;
    reg evt_limit;
    reg evt_error;
    // bus side
    reg [31:0] rdata;
    reg [`PUDC_IRQ_W-1:0] irq_set;

    wire dir_down = ctrl_r[`PUDC_CTL_DOWN];
    wire fall_sel = ctrl_r[`PUDC_CTL_FALL];
    wire [1:0] src_sel = ctrl_r[`PUDC_CTL_SRC];
    wire [1:0] lim_sel = ctrl_r[`PUDC_CTL_LIM];
    wire lim_err = (lim_sel == `PUDC_LIM_ERR);
    wire lim_clamp = (lim_sel == `PUDC_LIM_CLAMP);
    wire lim_on = lim_err | lim_clamp;
    wire ext_hold = ~ers_s2_r;
    wire edge_stb;
    wire [PW-1:0] divisor;
    wire tick;
    wire [CW-1:0] start_val;
    wire req = wb_cyc_i & wb_stb_i;
    wire wr_en = req & wb_we_i & wb_ack_o;
    wire sc_idle;
    wire sc_done;
    wire [DW-1:0] sc_quot;
    wire [31:0] wr_data;

    // byte-lane merge so that sel gates every write but the interrupt clear, which takes wb_dat_i whole
    function [31:0] wmerge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer i;
        begin
            wmerge = old;
            for (i = 0; i < 4; i = i + 1)
                if (sel[i])
                    wmerge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // lanes merged onto the addressed register's own read value
    assign wr_data = wmerge(rdata, wb_dat_i, wb_sel_i);

    // pull resistors follow the chosen input source
    assign pull_up_en = (src_sel == `PUDC_SRC_SINK);
    assign pull_down_en = (src_sel == `PUDC_SRC_SOURCE);

    // two synchroniser flops and one history flop per pin; the first stage feeds only the second
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_s1_r <= 1'b0;
            cnt_s2_r <= 1'b0;
            cnt_d_r <= 1'b0;
            ers_s1_r <= 1'b1;
            ers_s2_r <= 1'b1;
            ers_d_r <= 1'b1;
        end
        else
        begin
            cnt_s1_r <= cnt_pin;
            cnt_s2_r <= cnt_s1_r;
            cnt_d_r <= cnt_s2_r;
            ers_s1_r <= ext_rst_pin_n;
            ers_s2_r <= ers_s1_r;
            ers_d_r <= ers_s2_r;
        end
    end

    // no debouncing: a bouncing contact counts every bounce
    assign edge_stb = fall_sel ? (cnt_d_r & ~cnt_s2_r) : (~cnt_d_r & cnt_s2_r);

    // a prescale of zero is read as one, so no edge is ever swallowed
    assign divisor = (prescale_r == {PW{1'b0}}) ? PRE_ONE : prescale_r;
    assign tick = edge_stb & ~ext_hold & state_r[1] & (pre_cnt_r == divisor - PRE_ONE);

    // prescaler restarts with the counter under external reset
    always @(posedge clk)
    begin
        if (!rst_n)
            pre_cnt_r <= {PW{1'b0}};
        else if (ext_hold)
            pre_cnt_r <= {PW{1'b0}};
        else if (tick)
            pre_cnt_r <= {PW{1'b0}};
        else if (edge_stb)
            pre_cnt_r <= pre_cnt_r + PRE_ONE;
    end

    assign start_val = dir_down ? upper_r : CNT_ZERO;

    // next count, range flags and events
    always @*
    begin
        count_nxt = count_r;
        over_nxt = over_r;
        under_nxt = under_r;
        abs_err_nxt = abs_err_r;
        evt_limit = 1'b0;
        evt_error = 1'b0;
        if (ext_hold)
        begin
            count_nxt = start_val;
            over_nxt = 1'b0;
            under_nxt = 1'b0;
            abs_err_nxt = 1'b0;
        end
        else if (tick && !dir_down)
        begin
            if (count_r == ABS_MAX)
            begin
                abs_err_nxt = 1'b1;
                evt_error = 1'b1;
            end
            else if (lim_on && count_r >= upper_r)
            begin
                // bounded: count parks on the limit
                over_nxt = 1'b1;
                evt_error = lim_err;
            end
            else
            begin
                count_nxt = count_r + CNT_ONE;
                evt_limit = (count_r + CNT_ONE == upper_r);
            end
        end
        else if (tick && dir_down)
        begin
            if (count_r == CNT_ZERO)
            begin
                under_nxt = 1'b1;
                evt_error = lim_err;
            end
            else
            begin
                count_nxt = count_r - CNT_ONE;
                evt_limit = (count_r == CNT_ONE);
            end
        end
    end

    // restore from the store once, on the first cycle after reset
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= ST_RESTORE;
            count_r <= CNT_ZERO;
            over_r <= 1'b0;
            under_r <= 1'b0;
            abs_err_r <= 1'b0;
            nv_save_stb <= 1'b0;
            nv_save_value <= CNT_ZERO;
        end
        else
        begin
            nv_save_stb <= 1'b0;
            case (state_r)
                ST_RESTORE:
                begin
                    count_r <= nv_load_valid ? nv_load_value : start_val;
                    state_r <= ST_RUN;
                end
                ST_RUN:
                begin
                    count_r <= count_nxt;
                    over_r <= over_nxt;
                    under_r <= under_nxt;
                    abs_err_r <= abs_err_nxt;
                    // every change is pushed out so a power loss keeps it
                    if (count_nxt != count_r)
                    begin
                        nv_save_stb <= 1'b1;
                        nv_save_value <= count_nxt;
                    end
                end
                default:
                    state_r <= ST_RESTORE;
            endcase
        end
    end

    // scaler recomputes continuously; output lags the count by one pass
    pudc_scaler #(
        .CW(CW),
        .DW(DW)
    ) u_scaler (
        .clk(clk),
        .rst_n(rst_n),
        .start(sc_idle),
        .count(count_r),
        .scale(disp_lim_r),
        .limit(upper_r),
        .idle(sc_idle),
        .done_r(sc_done),
        .quot_r(sc_quot)
    );

    // shown value, decimal point and error indication
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            disp_value <= {DW{1'b0}};
            disp_dp <= 3'h0;
            disp_err <= 1'b0;
        end
        else
        begin
            disp_dp <= ctrl_r[`PUDC_CTL_DP];
            disp_err <= abs_err_r | (lim_err & (over_r | under_r));
            if (lim_clamp && over_r)
                disp_value <= disp_lim_r;
            else if (lim_clamp && under_r)
                disp_value <= {DW{1'b0}};
            else if (sc_done)
                disp_value <= sc_quot;
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always @*
    begin
        irq_set = {`PUDC_IRQ_W{1'b0}};
        irq_set[`PUDC_IRQ_PULSE] = tick;
        irq_set[`PUDC_IRQ_LIMIT] = evt_limit & state_r[1];
        irq_set[`PUDC_IRQ_ERROR] = evt_error & state_r[1];
        irq_set[`PUDC_IRQ_EXTRST] = ers_d_r & ~ers_s2_r;
    end

    assign irq = |(irq_stat_r & irq_en_r);

    // wishbone register writes, committed on the acknowledging edge
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_r <= RST_CTRL;
            prescale_r <= RST_PRE;
            upper_r <= RST_UPPER;
            disp_lim_r <= RST_DLIM;
            irq_en_r <= {`PUDC_IRQ_W{1'b0}};
            irq_stat_r <= {`PUDC_IRQ_W{1'b0}};
        end
        else
        begin
            if (wr_en && wb_adr_i == `PUDC_OFF_CTRL)
                ctrl_r <= wr_data[`PUDC_CTL_W-1:0];
            if (wr_en && wb_adr_i == `PUDC_OFF_PRESCALE)
                prescale_r <= wr_data[PW-1:0];
            if (wr_en && wb_adr_i == `PUDC_OFF_UPPER)
                upper_r <= wr_data[CW-1:0];
            if (wr_en && wb_adr_i == `PUDC_OFF_DISP_LIM)
                disp_lim_r <= wr_data[DW-1:0];
            if (wr_en && wb_adr_i == `PUDC_OFF_IRQ_EN)
                irq_en_r <= wr_data[`PUDC_IRQ_W-1:0];
            if (wr_en && wb_adr_i == `PUDC_OFF_IRQ_CLR)
                irq_stat_r <= (irq_stat_r & ~wb_dat_i[`PUDC_IRQ_W-1:0]) | irq_set;
            else
                irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    // read mux; unmapped and write-only offsets read zero
    always @*
    begin
        rdata = 32'h00000000;
        case (wb_adr_i)
            `PUDC_OFF_CTRL: rdata[`PUDC_CTL_W-1:0] = ctrl_r;
            `PUDC_OFF_PRESCALE: rdata[PW-1:0] = prescale_r;
            `PUDC_OFF_UPPER: rdata[CW-1:0] = upper_r;
            `PUDC_OFF_DISP_LIM: rdata[DW-1:0] = disp_lim_r;
            `PUDC_OFF_COUNT: rdata[CW-1:0] = count_r;
            `PUDC_OFF_DISPLAY:
            begin
                rdata[DW-1:0] = disp_value;
                rdata[`PUDC_DSP_DP] = disp_dp;
                rdata[`PUDC_DSP_ERR] = disp_err;
            end
            `PUDC_OFF_IRQ_STAT: rdata[`PUDC_IRQ_W-1:0] = irq_stat_r;
            `PUDC_OFF_IRQ_EN: rdata[`PUDC_IRQ_W-1:0] = irq_en_r;
            default: rdata = 32'h00000000;
        endcase
    end

    // one wait state: ack one cycle after the request, dropped the next
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o)
                wb_dat_o <= rdata;
        end
    end
endmodule // pudc_top

`default_nettype wire

// [tb/pudc_assertions.sv]
// port timing checker of the pulse up/down counter
`default_nettype none
module pudc_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic ext_rst_pin_n,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    input wire logic nv_save_stb,
    input wire logic [2:0] disp_dp,
    input wire logic disp_err,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // bus answers exactly one edge after the request is taken
    ack_next_edge_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one edge after request");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    // both pulls at once would short the contact line
    pull_exclusive_a: assert property (!(pull_up_en && pull_down_en))
        else $error("pull-up and pull-down both on");
    pull_by_write_a: assert property (
        $changed(pull_up_en) || $changed(pull_down_en) |-> $past(wb_ack_o))
        else $error("pull setting moved without a write");
    dp_by_write_a: assert property ($changed(disp_dp) |->
        $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
        else $error("decimal point moved without a write");
    // a held external reset pins the count, so nothing is saved
    ext_hold_a: assert property (!ext_rst_pin_n [*6] |-> !nv_save_stb)
        else $error("count changed under external reset");
    save_single_a: assert property (nv_save_stb |=> !nv_save_stb)
        else $error("one edge gave two count steps");
    irq_clear_write_a: assert property ($fell(irq) |-> $past(wb_ack_o))
        else $error("interrupt fell without a write");

    cover property (wb_ack_o);
    cover property ($rose(irq));
    cover property ($rose(disp_err));
    cover property ($rose(pull_up_en));
endmodule // pudc_checker

bind pudc_top pudc_checker chk_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ext_rst_pin_n(ext_rst_pin_n),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .nv_save_stb(nv_save_stb),
    .disp_dp(disp_dp), .disp_err(disp_err), .irq(irq));
`default_nettype wire

// [tb/pudc_pulse_src.sv]
// pulse transmitter or switching contact feeding the counter pin
`default_nettype none
module pudc_pulse_src (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] src,
    input wire logic [7:0] n,
    input wire logic [4:0] hold,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic act;
    logic last_r;

    // each press is one clean close and open, no bounce
    initial
    begin
        act = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                busy <= 1'b1;
                repeat (n)
                begin
                    act <= 1'b1;
                    repeat (hold) @(posedge clk);
                    act <= 1'b0;
                    repeat (hold) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end

    // an open contact with no pull floats: show a changing level
    always_comb
        case (src)
            2'h1: pin = act ? 1'b0 : (pull_up_en ? 1'b1 : ~last_r);
            2'h2: pin = act ? 1'b1 : (pull_down_en ? 1'b0 : ~last_r);
            default: pin = act;
        endcase

    always @(posedge clk)
        last_r <= pin;
endmodule // pudc_pulse_src
`default_nettype wire

// [tb/pudc_top_tb_top.sv]
// self-checking bench of the pulse up/down counter
`include "pudc_defs.vh"
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module pudc_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, cyc = 0, we = 0, ext_n = 1, go = 0, nv_v = 1;
    logic pin, busy, ack, up_en, dn_en, save, err, irq;
    logic [7:0] adr = 0, np = 0;
    logic [4:0] hp = 1;
    logic [1:0] srcm = 0;
    logic [31:0] wd = 0, rd, rq;
    logic [23:0] sv;
    logic [15:0] disp;
    logic [2:0] dp;
    int n_errors = 0, cmp_count = 0;

    always #12.5 clk = ~clk;

    pudc_top dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
        .wb_ack_o(ack), .cnt_pin(pin), .ext_rst_pin_n(ext_n), .pull_up_en(up_en),
        .pull_down_en(dn_en), .nv_load_valid(nv_v), .nv_load_value(24'h000005),
        .nv_save_stb(save), .nv_save_value(sv), .disp_value(disp), .disp_dp(dp),
        .disp_err(err), .irq(irq));
    pudc_pulse_src src_u (.clk(clk), .go(go), .src(srcm), .n(np), .hold(hp),
        .pull_up_en(up_en), .pull_down_en(dn_en), .pin(pin), .busy(busy));

    // one classic wishbone cycle; waits for ack, no fixed latency assumed
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        if (k >= 50) n_errors++;
        rq = rd;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ck(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        `CHK(rq, e)
    endtask
    task automatic start(input int n, input int h);
        np <= 8'(n);
        hp <= 5'(h);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic drain();
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (busy === 1'b1 && k < 3000);
        repeat (6) @(posedge clk);
    endtask
    task automatic pulses(input int n);
        start(n, 2);
        drain();
    endtask
    // settings, then an external reset so the count restarts
    task automatic cfg(input int c, input int p, input int u, input int dl);
        bus(`PUDC_OFF_CTRL, 1'b1, 32'(c));
        bus(`PUDC_OFF_PRESCALE, 1'b1, 32'(p));
        bus(`PUDC_OFF_UPPER, 1'b1, 32'(u));
        bus(`PUDC_OFF_DISP_LIM, 1'b1, 32'(dl));
        bus(`PUDC_OFF_IRQ_CLR, 1'b1, 32'hF);
        ext_n <= 1'b0;
        repeat (6) @(posedge clk);
        ext_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_reset();
        ck(`PUDC_OFF_CTRL, 32'h0);
        ck(`PUDC_OFF_PRESCALE, 32'h1);
        ck(`PUDC_OFF_UPPER, 32'hFFFF);
        ck(`PUDC_OFF_DISP_LIM, 32'h270F);
        ck(`PUDC_OFF_COUNT, 32'h5);
        ck(8'h24, 32'h0);
        ck(`PUDC_OFF_IRQ_CLR, 32'h0);
    endtask
    task automatic t_up_presc();
        cfg(0, 3, 10, 10);
        ck(`PUDC_OFF_COUNT, 32'h0);
        bus(`PUDC_OFF_IRQ_EN, 1'b1, 32'h1);
        pulses(7);
        ck(`PUDC_OFF_COUNT, 32'h2);
        `CHK(sv, 24'h000002)
        `CHK(irq, 1'b1)
        bus(`PUDC_OFF_IRQ_CLR, 1'b1, 32'h1);
        `CHK(irq, 1'b0)
        ck(`PUDC_OFF_IRQ_STAT, 32'h8);
        repeat (100) @(posedge clk);
        `CHK(disp, 16'h0002)
        bus(`PUDC_OFF_IRQ_EN, 1'b1, 32'h0);
    endtask
    task automatic t_edge();
        for (int f = 0; f < 2; f++)
        begin
            cfg(f << 1, 1, 100, 100);
            start(1, 12);
            repeat (7) @(posedge clk);
            ck(`PUDC_OFF_COUNT, 32'(1 - f));
            drain();
            ck(`PUDC_OFF_COUNT, 32'h1);
        end
    endtask
    task automatic t_down();
        cfg(32'h21, 1, 4, 100);
        ck(`PUDC_OFF_COUNT, 32'h4);
        pulses(6);
        ck(`PUDC_OFF_COUNT, 32'h0);
        repeat (100) @(posedge clk);
        `CHK(disp, 16'h0000)
        `CHK(err, 1'b0)
        cfg(32'h11, 1, 4, 100);
        pulses(5);
        repeat (100) @(posedge clk);
        `CHK(err, 1'b1)
    endtask
    task automatic t_up_lim();
        cfg(0, 1, 2, 100);
        pulses(4);
        ck(`PUDC_OFF_COUNT, 32'h4);
        cfg(32'h10, 1, 2, 100);
        pulses(4);
        ck(`PUDC_OFF_COUNT, 32'h2);
        ck(`PUDC_OFF_IRQ_STAT, 32'hF);
        repeat (100) @(posedge clk);
        `CHK(err, 1'b1)
        cfg(32'h160, 1, 2, 100);
        pulses(4);
        repeat (100) @(posedge clk);
        `CHK(disp, 16'h0064)
        `CHK(err, 1'b0)
        `CHK(dp, 3'h5)
    endtask
    task automatic t_ext();
        cfg(0, 1, 100, 100);
        pulses(3);
        ext_n <= 1'b0;
        pulses(2);
        ck(`PUDC_OFF_COUNT, 32'h0);
        ext_n <= 1'b1;
        repeat (4) @(posedge clk);
        pulses(1);
        ck(`PUDC_OFF_COUNT, 32'h1);
        `CHK(sv, 24'h000001)
    endtask
    // contact moved first so its float settles before the count restarts
    task automatic t_src();
        for (int s = 1; s < 3; s++)
        begin
            srcm <= 2'(s);
            cfg(s << 2, 1, 100, 100);
            `CHK({up_en, dn_en}, 2'(3 - s))
            pulses(2);
            ck(`PUDC_OFF_COUNT, 32'h2);
        end
        srcm <= 2'h0;
    endtask

    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        nv_v <= 1'b0;
        t_reset();
        t_up_presc();
        t_edge();
        t_down();
        t_up_lim();
        t_ext();
        t_src();
        final_report();
    end
    // the whole run needs some 1200 cycles
    initial
    begin
        repeat (30000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule // pudc_top_tb_top
`default_nettype wire
